/* File: core/lifs_pkg.sv */
// Constants and types shared by the lamp ignition and fault sequencer
package lifs_pkg;

   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned STARTUP_TIME_MS = 1000;
   localparam int unsigned STARTUP_CYC = STARTUP_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned SW_MAX_FREQ_KHZ = 1000;
   localparam int unsigned SW_MIN_PERIOD_CYC = CLK_HZ / (SW_MAX_FREQ_KHZ * 1000);
   localparam int unsigned DIM_PERIOD_US = 6000;
   localparam int unsigned DIM_STEPS = 256;
   localparam int unsigned DIM_STEP_CYC = (DIM_PERIOD_US * (CLK_HZ / 1_000_000)) / DIM_STEPS;

   // ------------------------------------------------------------------
   // Levels and counts
   // ------------------------------------------------------------------
   localparam logic [7:0] LEVEL_ZERO = 8'h00;
   localparam logic [7:0] LEVEL_FULL = 8'hFF;
   localparam logic [7:0] FREQ_OV_LEVEL = 8'h33;
   localparam logic [2:0] UNDER_LIMIT = 3'h4;
   localparam logic [1:0] FULL_DIM_CYCLES = 2'h2;
   localparam int unsigned RAMP_W = 25;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam int unsigned CTRL_POL_BIT = 0;
   localparam int unsigned CTRL_BRIGHTNESS_INPUT_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_FF00;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_OFF = 5'b00001,
      ST_START = 5'b00010,
      ST_FULL = 5'b00100,
      ST_RUN = 5'b01000,
      ST_FAULT = 5'b10000
   } lifs_state_type;

   typedef struct packed {
      logic strike;
      logic low_ov;
      logic high_ov;
   } lifs_sense_type;

   typedef struct packed {
      logic high_ov;
      logic low_ov;
      logic under;
   } lifs_cause_type;

endpackage

/* File: core/lifs_sequencer.sv */
// Lamp ignition and fault sequencer with Wishbone register access
`timescale 1ns/1ps
`default_nettype none

// Function
// - Power-up or enable rising edge enters start-up with timer ramp and frequency level zero.
// - Strike sense high ends start-up and begins steady state.
// - Start-up expires when the timer ramp reaches its threshold.
// - Expiry without strike shuts down until reset or a new enable rising edge.
// - Frequency level zero gives maximum frequency; full scale gives minimum.
// - In start-up, low overvoltage below threshold keeps raising the frequency level.
// - In start-up, low above and high below threshold holds the frequency level.
// - In start-up, high overvoltage forces level one fifth, soft start zero, duty zero.
// - Soft start ramps from zero capping duty; at full scale duty is free.
// - After strike, full brightness for two dimming cycles, then brightness control.
// - Each dimming on-period clears soft start then ramps it to full scale.
// - In steady state high overvoltage shuts down at once, without blanking.
// - In steady state low overvoltage shuts down only outside blanking.
// - After blanking, four consecutive weak-strike cycles shut down; a good cycle restarts count.
// - Timer ramp is cleared whenever the lamp turns off, then ramps again.
// - Blanking lasts from ramp clear to threshold, disabling low and undercurrent checks.
// - No sense level raises a fault during start-up.
// - A steady-state fault latches off until reset or enable toggle.
module lifs_sequencer #(
   parameter int unsigned STARTUP_CYC = lifs_pkg::STARTUP_CYC
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Chip enable and comparator flags
   input wire logic i_chip_enable,
   input wire lifs_pkg::lifs_sense_type i_sense,
   // Power stage controls
   output logic o_switch_en,
   output logic o_switch_tick,
   output logic [7:0] o_duty_cap,
   output logic [7:0] o_frequency_control_level,
   output logic [7:0] o_soft_start_level,
   output lifs_pkg::lifs_state_type o_state
);
   import lifs_pkg::*;

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   lifs_state_type state;
   lifs_state_type next_state;
   lifs_sense_type sense_meta;
   lifs_sense_type sense_sync;
   lifs_sense_type sense_smp;
   lifs_cause_type cause;
   logic ce_q;
   logic ce_rise;
   logic [8:0] osc_cnt;
   logic [8:0] period_m1;
   logic sw_tick;
   logic smp_stb;
   logic [15:0] dim_div;
   logic [7:0] dim_ramp;
   logic dim_step;
   logic dim_wrap;
   logic dim_on;
   logic [RAMP_W-1:0] ramp;
   logic ramp_expired;
   logic [7:0] freq_level;
   logic [7:0] soft_start;
   logic [1:0] full_cycles;
   logic [2:0] under_cnt;
   logic steady;
   logic lamp_on;
   logic ov_hold;
   logic fault_hi;
   logic fault_lo;
   logic fault_uc;
   logic [31:0] ctrl;
   logic [7:0] brightness;
   logic polarity;
   logic wb_req;

   // ------------------------------------------------------------------
   // Enable edge and sense sampling
   // ------------------------------------------------------------------
   assign ce_rise = i_chip_enable & ~ce_q;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         ce_q <= 1'b0;
      end else begin
         ce_q <= i_chip_enable;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         sense_meta <= '0;
         sense_sync <= '0;
         sense_smp <= '0;
         smp_stb <= 1'b0;
      end else begin
         sense_meta <= i_sense;
         sense_sync <= sense_meta;
         smp_stb <= sw_tick;
         if (sw_tick) begin
            sense_smp <= sense_sync;
         end
      end
   end

   // ------------------------------------------------------------------
   // Switching oscillator: higher level, longer period
   // ------------------------------------------------------------------
   assign period_m1 = 9'(SW_MIN_PERIOD_CYC - 1) + {1'b0, freq_level};
   assign sw_tick = (osc_cnt >= period_m1);

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         osc_cnt <= 9'h000;
      end else if (sw_tick) begin
         osc_cnt <= 9'h000;
      end else begin
         osc_cnt <= osc_cnt + 9'h001;
      end
   end

   // ------------------------------------------------------------------
   // Dimming ramp and brightness compare
   // ------------------------------------------------------------------
   assign dim_step = (dim_div == 16'(DIM_STEP_CYC - 1));
   assign dim_wrap = dim_step & (dim_ramp == LEVEL_FULL);
   assign brightness = ctrl[CTRL_BRIGHTNESS_INPUT_LSB +: 8];
   assign polarity = ctrl[CTRL_POL_BIT];
   assign dim_on = polarity ? (dim_ramp >= brightness) : (dim_ramp < brightness);

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         dim_div <= 16'h0000;
         dim_ramp <= 8'h00;
      end else if (dim_step) begin
         dim_div <= 16'h0000;
         dim_ramp <= dim_ramp + 8'h01;
      end else begin
         dim_div <= dim_div + 16'h0001;
      end
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   assign steady = (state == ST_FULL) | (state == ST_RUN);
   assign lamp_on = (state == ST_START) | (state == ST_FULL) | ((state == ST_RUN) & dim_on);
   assign ov_hold = (state == ST_START) & sense_smp.high_ov;
   assign ramp_expired = (32'(ramp) >= STARTUP_CYC);
   assign fault_hi = steady & lamp_on & sense_smp.high_ov;
   assign fault_lo = steady & lamp_on & ramp_expired & sense_smp.low_ov;
   assign fault_uc = steady & lamp_on & (under_cnt == UNDER_LIMIT);

   always_comb begin
      next_state = state;
      case (state)
         ST_START: begin
            if (sense_smp.strike) begin
               next_state = ST_FULL;
            end else if (ramp_expired) begin
               next_state = ST_OFF;
            end
         end
         ST_FULL: begin
            if (fault_hi | fault_lo | fault_uc) begin
               next_state = ST_FAULT;
            end else if (full_cycles == FULL_DIM_CYCLES) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (fault_hi | fault_lo | fault_uc) begin
               next_state = ST_FAULT;
            end
         end
         default: begin
            next_state = state;
         end
      endcase
      if (ce_rise) begin
         next_state = ST_START;
      end else if (!i_chip_enable) begin
         next_state = ST_OFF;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         state <= ST_START;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         cause <= '0;
      end else if (ce_rise) begin
         cause <= '0;
      end else if (steady && next_state == ST_FAULT) begin
         cause <= '{high_ov: fault_hi, low_ov: fault_lo, under: fault_uc};
      end
   end

   // ------------------------------------------------------------------
   // Start-up timer ramp, also the blanking timer
   // ------------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || ce_rise || !lamp_on) begin
         ramp <= '0;
      end else if (!ramp_expired) begin
         ramp <= ramp + RAMP_W'(1);
      end
   end

   // ------------------------------------------------------------------
   // Frequency control level
   // ------------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || ce_rise) begin
         freq_level <= LEVEL_ZERO;
      end else if (state == ST_START && smp_stb) begin
         if (sense_smp.high_ov) begin
            freq_level <= FREQ_OV_LEVEL;
         end else if (!sense_smp.low_ov && freq_level != LEVEL_FULL) begin
            freq_level <= freq_level + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // Soft start and duty cap
   // ------------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || !lamp_on || ov_hold) begin
         soft_start <= LEVEL_ZERO;
      end else if (smp_stb && soft_start != LEVEL_FULL) begin
         soft_start <= soft_start + 8'h01;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_switch_en <= 1'b0;
         o_duty_cap <= LEVEL_ZERO;
      end else begin
         o_switch_en <= lamp_on & ~ov_hold;
         o_duty_cap <= (lamp_on & ~ov_hold) ? soft_start : LEVEL_ZERO;
      end
   end

   // ------------------------------------------------------------------
   // Full-brightness and undercurrent counters
   // ------------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || state != ST_FULL) begin
         full_cycles <= 2'h0;
      end else if (dim_wrap) begin
         full_cycles <= full_cycles + 2'h1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst || !steady || !lamp_on || !ramp_expired) begin
         under_cnt <= 3'h0;
      end else if (smp_stb) begin
         if (sense_smp.strike) begin
            under_cnt <= 3'h0;
         end else if (under_cnt != UNDER_LIMIT) begin
            under_cnt <= under_cnt + 3'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Wishbone registers
   // ------------------------------------------------------------------
   assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         ctrl <= CTRL_RESET;
      end else if (wb_req && i_wb_we && i_wb_adr == REG_CTRL) begin
         for (int b = 0; b < 4; b++) begin
            if (i_wb_sel[b]) begin
               ctrl[b*8 +: 8] <= i_wb_dat[b*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= wb_req;
         if (!wb_req || i_wb_we) begin
            o_wb_dat <= 32'h0000_0000;
         end else if (i_wb_adr == REG_CTRL) begin
            o_wb_dat <= {23'h00_0000, ctrl[15:8], ctrl[0]};
         end else if (i_wb_adr == REG_STATUS) begin
            o_wb_dat <= {soft_start, freq_level, 5'h00, cause, 3'h0, state};
         end else begin
            o_wb_dat <= 32'h0000_0000;
         end
      end
   end

   assign o_switch_tick = sw_tick;
   assign o_frequency_control_level = freq_level;
   assign o_soft_start_level = soft_start;
   assign o_state = state;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   AST_CE_RISE_START: assert property (ce_rise |=> state == ST_START && ramp == '0 && freq_level == LEVEL_ZERO)
      else $error("enable rise did not restart start-up");
   AST_STRIKE_ENDS: assert property (state == ST_START && sense_smp.strike && i_chip_enable && !ce_rise
      |=> state == ST_FULL)
      else $error("strike did not end start-up");
   AST_TIMEOUT_OFF: assert property (state == ST_START && !sense_smp.strike && ramp_expired && i_chip_enable
      && !ce_rise |=> state == ST_OFF)
      else $error("start-up expiry did not shut down");
   AST_OFF_STAYS: assert property ((state == ST_OFF || state == ST_FAULT) && !ce_rise
      |=> state == $past(state) || state == ST_OFF)
      else $error("latched state left without enable rise");
   AST_FREQ_RISE: assert property (state == ST_START && smp_stb && !sense_smp.high_ov && !sense_smp.low_ov
      && freq_level != LEVEL_FULL && !ce_rise |=> freq_level == $past(freq_level) + 8'h01)
      else $error("frequency level did not step up");
   AST_FREQ_HOLD: assert property (state == ST_START && smp_stb && !sense_smp.high_ov && sense_smp.low_ov
      && !ce_rise |=> $stable(freq_level))
      else $error("frequency level moved while held");
   AST_OV_DROP: assert property (state == ST_START && smp_stb && sense_smp.high_ov && !ce_rise
      |=> freq_level == FREQ_OV_LEVEL ##1 o_duty_cap == LEVEL_ZERO)
      else $error("high overvoltage not handled in start-up");
   AST_HI_FAULT: assert property (fault_hi && i_chip_enable && !ce_rise |=> state == ST_FAULT)
      else $error("high overvoltage did not latch fault");
   AST_UNDER_FAULT: assert property (fault_uc && i_chip_enable && !ce_rise |=> state == ST_FAULT)
      else $error("undercurrent count did not latch fault");
   AST_OUTPUT_OFF: assert property (state == ST_OFF || state == ST_FAULT
      |=> !o_switch_en && o_duty_cap == LEVEL_ZERO)
      else $error("outputs active while shut down");

   COV_STRIKE: cover property (state == ST_START ##1 state == ST_FULL);
   COV_RUN: cover property (state == ST_FULL ##1 state == ST_RUN);
   COV_FAULT: cover property (state == ST_RUN ##1 state == ST_FAULT);
   COV_TIMEOUT: cover property (state == ST_START ##1 state == ST_OFF);

endmodule

`default_nettype wire

/* File: verif/lifs_lamp_model.sv */
// Behavioural power stage and lamp sense comparators
`timescale 1ns/1ps
`default_nettype none

module lifs_lamp_model (
   // Clock
   input wire logic i_sys_clk,
   // Scenario controls from the bench
   input wire logic i_strike_cmd,
   input wire logic i_low_cmd,
   input wire logic i_high_cmd,
   // Power stage view
   input wire logic i_switch_en,
   // Comparator flags
   output var lifs_pkg::lifs_sense_type o_sense
);
   import lifs_pkg::*;

   // ------------------------------------------------------------------
   // Comparators
   // ------------------------------------------------------------------
   // Lamp current only flows while the stage is switching
   always_ff @(posedge i_sys_clk) begin
      o_sense.strike <= i_strike_cmd & i_switch_en;
      o_sense.low_ov <= i_low_cmd;
      o_sense.high_ov <= i_high_cmd;
   end

endmodule

`default_nettype wire

/* File: verif/test_lamp_ignition_fault_sequencer.sv */
// Self-checking bench for the lamp ignition and fault sequencer
`timescale 1ns/1ps
`default_nettype none

module test_lamp_ignition_fault_sequencer;
   import lifs_pkg::*;

   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   localparam int unsigned SIM_STARTUP = 1000;
   localparam logic [31:0] M_ALL = 32'hFFFF_FFFF;
   localparam logic [31:0] M_NOSS = 32'h00FF_FFFF;
   localparam logic [31:0] M_ST = 32'h0000_071F;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [3:0] wb_adr = 4'h0;
   logic [31:0] wb_dat = 32'h0000_0000;
   logic [31:0] rd_dat;
   logic ack;
   logic chip_en = 1'b1;
   logic strike_cmd = 1'b0;
   logic low_cmd = 1'b1;
   logic high_cmd = 1'b0;
   logic switch_en;
   logic tick;
   logic [7:0] duty_pin;
   logic [7:0] freq_pin;
   logic [7:0] soft_pin;
   lifs_state_type state_pin;
   lifs_sense_type sense;
   int bad_count = 0;
   int total_checks = 0;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [31:0] wr_val;

   lifs_sequencer #(.STARTUP_CYC(SIM_STARTUP)) dut (
      .i_sys_clk(sys_clk), .i_srst(srst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
      .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hF), .i_wb_dat(wb_dat),
      .o_wb_dat(rd_dat), .o_wb_ack(ack), .i_chip_enable(chip_en), .i_sense(sense),
      .o_switch_en(switch_en), .o_switch_tick(tick), .o_duty_cap(duty_pin),
      .o_frequency_control_level(freq_pin), .o_soft_start_level(soft_pin), .o_state(state_pin));

   lifs_lamp_model lamp (
      .i_sys_clk(sys_clk), .i_strike_cmd(strike_cmd), .i_low_cmd(low_cmd),
      .i_high_cmd(high_cmd), .i_switch_en(switch_en), .o_sense(sense));

   initial begin
      forever #25 sys_clk = ~sys_clk;
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   function automatic logic [31:0] st(input logic [7:0] f, input logic [2:0] c, input lifs_state_type s);
      return {8'h00, f, 5'h00, c, 3'h0, s};
   endfunction

   // Power stage pins packed as {switch enable, duty cap, frequency level, state}
   function automatic logic [31:0] pins();
      return {7'h00, switch_en, duty_pin, freq_pin, 3'h0, state_pin};
   endfunction

   task automatic give_verdict();
      if (bad_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check_rd(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
      total_checks++;
      if ((got & m) !== (e & m)) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got & m, e & m);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Classic single Wishbone cycle; reads leave their expectation in the queue
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
      int n;
      if (!w) begin
         exp_q.push_back(e);
         msk_q.push_back(m);
      end
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= d;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad_count++;
         give_verdict();
      end
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wait_tick(input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         k = 0;
         do begin
            @(posedge sys_clk);
            k++;
         end while (tick !== 1'b1 && k < 400);
         if (k >= 400) begin
            bad_count++;
            give_verdict();
         end
      end
   endtask

   task automatic restart(input logic s, input logic l, input logic h);
      chip_en <= 1'b0;
      strike_cmd <= s;
      low_cmd <= l;
      high_cmd <= h;
      idle(3 + int'($urandom % 8));
      chip_en <= 1'b1;
      idle(1);
   endtask

   // Read results are matched against the oldest note
   always @(posedge sys_clk) begin
      if (ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
         check_rd(rd_dat, exp_q.pop_front(), msk_q.pop_front());
      end
   end

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(32'hdf7241d7));
      idle(16);
      srst <= 1'b0;
      idle(1);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h0, ST_START), M_ALL);
      wb(1'b0, REG_CTRL, 32'h0000_0000, {23'h00_0000, CTRL_RESET[CTRL_BRIGHTNESS_INPUT_LSB +: 8], CTRL_RESET[CTRL_POL_BIT]}, M_ALL);
      wr_val = {16'h0000, 8'($urandom), 7'h00, 1'($urandom)};
      wb(1'b1, REG_CTRL, wr_val, 32'h0000_0000, 32'h0000_0000);
      wb(1'b1, 4'h8, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
      wb(1'b0, REG_CTRL, 32'h0000_0000, {23'h00_0000, wr_val[15:8], wr_val[0]}, M_ALL);
      wb(1'b0, 4'h8, 32'h0000_0000, 32'h0000_0000, M_ALL);
      wb(1'b1, REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
      idle(400);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h0, ST_START), M_NOSS);
      idle(800);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h0, ST_OFF), M_ST);
      idle(300);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h0, ST_OFF), M_ST);
      check_rd(pins(), {7'h00, 1'b0, LEVEL_ZERO, 8'h00, 3'h0, ST_OFF}, 32'hFFFF_00FF);
      restart(1'b0, 1'b1, 1'b0);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h0, ST_START), M_NOSS);
      high_cmd <= 1'b1;
      idle(200);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(FREQ_OV_LEVEL, 3'h0, ST_START), M_ALL);
      check_rd(pins(), {7'h00, 1'b0, LEVEL_ZERO, FREQ_OV_LEVEL, 3'h0, ST_START}, M_ALL);
      check_rd({24'h00_0000, soft_pin}, 32'h0000_0000, M_ALL);
      high_cmd <= 1'b0;
      idle(300);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(FREQ_OV_LEVEL, 3'h0, ST_START), M_NOSS);
      restart(1'b1, 1'b0, 1'b0);
      idle(200);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h0, ST_FULL), M_ST);
      check_rd(pins(), {7'h00, 1'b1, 8'h00, 8'h00, 3'h0, ST_FULL}, 32'h0100_001F);
      low_cmd <= 1'b1;
      idle(100);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h0, ST_FULL), M_ST);
      idle(1500);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h2, ST_FAULT), M_ST);
      check_rd(pins(), {7'h00, 1'b0, LEVEL_ZERO, 8'h00, 3'h0, ST_FAULT}, 32'hFFFF_00FF);
      restart(1'b1, 1'b0, 1'b0);
      idle(200);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h0, ST_FULL), M_ST);
      high_cmd <= 1'b1;
      idle(350);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h4, ST_FAULT), M_ST);
      high_cmd <= 1'b0;
      idle(200);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h4, ST_FAULT), M_ST);
      restart(1'b1, 1'b0, 1'b0);
      idle(1500);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h0, ST_FULL), M_ST);
      wait_tick(1);
      strike_cmd <= 1'b0;
      wait_tick(3);
      strike_cmd <= 1'b1;
      wait_tick(2);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h0, ST_FULL), M_ST);
      strike_cmd <= 1'b0;
      wait_tick(6);
      idle(5);
      wb(1'b0, REG_STATUS, 32'h0000_0000, st(8'h00, 3'h1, ST_FAULT), M_ST);
      idle(5);
      if (exp_q.size() != 0) begin
         bad_count++;
      end
      give_verdict();
   end

endmodule

`default_nettype wire
